// ===== include/tdc_pkg.sv
// Package for the tap detection configuration and status block
package tdc_pkg;

	// Register addresses
	localparam logic [7:0] TDC_ADDR_CONFIG = 8'h21;
	localparam logic [7:0] TDC_ADDR_SOURCE = 8'h22;
	localparam logic [7:0] TDC_ADDR_THR_X = 8'h23;
	localparam logic [7:0] TDC_ADDR_THR_Y = 8'h24;
	localparam logic [7:0] TDC_ADDR_THR_Z = 8'h25;

	// Reset values
	localparam logic [7:0] TDC_CONFIG_RST = 8'h00;
	localparam logic [6:0] TDC_THR_RST = 7'h00;
	localparam logic [7:0] TDC_SOURCE_RST = 8'h00;
	localparam logic [7:0] TDC_COUNT_RST = 8'h00;

	// Threshold scale: 7-bit field, LSB in ug, fixed full range in mg
	localparam int TDC_THR_LSB_UG = 63000;
	localparam int TDC_THR_RANGE_MG = 8000;
	// Reachable ceiling with low noise active, in mg, and as a code
	localparam int TDC_LOW_NOISE_MAX_MG = 4000;
	localparam logic [6:0] TDC_LOW_NOISE_MAX_CODE =
		7'((TDC_LOW_NOISE_MAX_MG * 1000) / TDC_THR_LSB_UG);

	// Source register field positions
	localparam int TDC_SRC_EA_BIT = 7;
	localparam int TDC_SRC_TYPE_BIT = 3;

	// Configuration register layout
	typedef struct packed {
		logic double_tap_abort_select;
		logic flag_latch_on;
		logic z_double_tap_enable;
		logic z_single_tap_enable;
		logic y_double_tap_enable;
		logic y_single_tap_enable;
		logic x_double_tap_enable;
		logic x_single_tap_enable;
	} tdc_config_t;

	// Source register layout; axis vectors are {z, y, x}
	typedef struct packed {
		logic tap_event_active;
		logic [2:0] tap_flag;
		logic double_tap_type;
		logic [2:0] tap_sign;
	} tdc_source_t;

	// Detected tap event handed to the source register
	typedef struct packed {
		logic valid;
		logic dbl;
		logic [2:0] axes;
		logic [2:0] sign;
	} tdc_event_t;

	// Detector states
	typedef enum logic [4:0] {
		TDC_IDLE = 5'b00001,
		TDC_FIRST = 5'b00010,
		TDC_LATENCY = 5'b00100,
		TDC_WINDOW = 5'b01000,
		TDC_SECOND = 5'b10000
	} tdc_state_t;

endpackage

// ===== core/tdc_core.sv
// Tap detector with configuration, threshold and source registers
//
// Function
// [RULE_01] Config register: abort, latch, six tap enables
// [RULE_02] Abort clear: latency taps do not stop detection
// [RULE_03] Abort set: tap inside latency suspends double
// [RULE_04] Latch on holds flags until source read
// [RULE_05] Report only enabled axis and tap type
// [RULE_06] Read-only source: active, axes, type, signs
// [RULE_07] Event active set when enabled event occurs
// [RULE_08] Axis flag set when tap on that axis
// [RULE_09] Type bit: zero single, one double
// [RULE_10] Sign bit: zero positive, one negative
// [RULE_11] Latched active freezes axes, type, signs
// [RULE_12] Source read clears all bits and request
// [RULE_13] Three 7-bit threshold registers, bit 7 zero
// [RULE_14] Threshold at 63 mg per LSB, 8g range
// [RULE_15] Low noise caps reachable threshold at 4g
// [RULE_16] Detection starts when axis exceeds threshold
// [RULE_17] Host programs thresholds from 1 to 127
// [RULE_18] Threshold fields reset to zero
// [RULE_19] Tap valid only if below within limit
// [RULE_20] Taps ignored during latency after first
// [RULE_21] Without latch, each new event updates source
`timescale 1ns/1ns
module tdc_core
	import tdc_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic SAMPLE_VALID,
	input wire logic signed [7:0] ACC_X,
	input wire logic signed [7:0] ACC_Y,
	input wire logic signed [7:0] ACC_Z,
	input wire logic LOW_NOISE,
	input wire logic [7:0] TIME_LIMIT,
	input wire logic [7:0] LATENCY,
	input wire logic [7:0] WINDOW,
	output logic TAP_IRQ
);

	// Magnitude of a signed sample, 128 fits in eight bits
	function automatic logic [7:0] mag8(input logic signed [7:0] v);
		logic [7:0] r;
		r = v[7] ? 8'(-v) : 8'(v);
		return r;
	endfunction

	// Threshold in force, capped when low noise is active
	function automatic logic [6:0] thr_cap(input logic [6:0] t,
		input logic ln);
		logic [6:0] r;
		r = (ln && t > TDC_LOW_NOISE_MAX_CODE) ? TDC_LOW_NOISE_MAX_CODE : t;
		return r;
	endfunction

	// Threshold readback, bit 7 always reads zero
	function automatic logic [7:0] thr_rd(input logic [6:0] t);
		logic [7:0] r;
		r = {1'b0, t};
		return r;
	endfunction

	tdc_config_t cfg_q;
	logic [6:0] thr_x_q;
	logic [6:0] thr_y_q;
	logic [6:0] thr_z_q;
	tdc_source_t src_q;
	tdc_source_t src_d;
	logic [7:0] rdata_q;
	tdc_state_t state_q;
	tdc_state_t state_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [2:0] axes_q;
	logic [2:0] axes_d;
	logic [2:0] sign_q;
	logic [2:0] sign_d;
	logic lat_seen_q;
	logic lat_seen_d;
	logic abort_q;
	logic abort_d;
	tdc_event_t ev;

	// Register decode
	wire wr_cfg = REG_WR && (REG_ADDR == TDC_ADDR_CONFIG);
	wire wr_thx = REG_WR && (REG_ADDR == TDC_ADDR_THR_X);
	wire wr_thy = REG_WR && (REG_ADDR == TDC_ADDR_THR_Y);
	wire wr_thz = REG_WR && (REG_ADDR == TDC_ADDR_THR_Z);
	wire rd_src = REG_RD && (REG_ADDR == TDC_ADDR_SOURCE);

	// Per-axis comparison, vectors are {z, y, x}
	// [RULE_14] Fixed scale compare
	wire [6:0] thr_eff_x = thr_cap(thr_x_q, LOW_NOISE);
	// [RULE_15] Low noise cap
	wire [6:0] thr_eff_y = thr_cap(thr_y_q, LOW_NOISE);
	wire [6:0] thr_eff_z = thr_cap(thr_z_q, LOW_NOISE);
	// [RULE_16] Exceed starts detection
	wire [2:0] above = {mag8(ACC_Z) > {1'b0, thr_eff_z},
		mag8(ACC_Y) > {1'b0, thr_eff_y},
		mag8(ACC_X) > {1'b0, thr_eff_x}};
	wire [2:0] neg = {ACC_Z[7], ACC_Y[7], ACC_X[7]};
	wire [2:0] single_en = {cfg_q.z_single_tap_enable,
		cfg_q.y_single_tap_enable, cfg_q.x_single_tap_enable};
	wire [2:0] double_en = {cfg_q.z_double_tap_enable,
		cfg_q.y_double_tap_enable, cfg_q.x_double_tap_enable};
	wire any_above = |above;
	wire tap_ended = ~|(above & axes_q);
	wire [7:0] cnt_inc = 8'(cnt_q + 8'h01);

	// Read data mux
	wire [7:0] cfg_rd = cfg_q;
	wire [7:0] src_rd = src_q;
	wire [7:0] rd_mux =
		(REG_ADDR == TDC_ADDR_CONFIG) ? cfg_rd :
		(REG_ADDR == TDC_ADDR_SOURCE) ? src_rd :
		(REG_ADDR == TDC_ADDR_THR_X) ? thr_rd(thr_x_q) :
		(REG_ADDR == TDC_ADDR_THR_Y) ? thr_rd(thr_y_q) :
		(REG_ADDR == TDC_ADDR_THR_Z) ? thr_rd(thr_z_q) : 8'h00;

	// Detector sequence
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		axes_d = axes_q;
		sign_d = sign_q;
		lat_seen_d = lat_seen_q;
		abort_d = abort_q;
		ev = '0;
		if (SAMPLE_VALID) begin
			case (state_q)
				TDC_IDLE: begin
					if (any_above) begin
						state_d = TDC_FIRST;
						cnt_d = TDC_COUNT_RST;
						axes_d = above;
						sign_d = neg;
					end
				end
				TDC_FIRST: begin
					// [RULE_19] Below within limit
					if (tap_ended) begin
						ev.valid = 1'b1;
						ev.dbl = 1'b0;
						ev.axes = axes_q & single_en;
						ev.sign = sign_q;
						state_d = TDC_LATENCY;
						cnt_d = TDC_COUNT_RST;
						lat_seen_d = 1'b0;
						abort_d = 1'b0;
					end else if (cnt_q >= TIME_LIMIT) begin
						state_d = TDC_IDLE;
					end else begin
						cnt_d = cnt_inc;
					end
				end
				TDC_LATENCY: begin
					// [RULE_20] Taps ignored here
					if (any_above) begin
						lat_seen_d = 1'b1;
					end
					// [RULE_03] Tap ends inside latency
					if (cfg_q.double_tap_abort_select && lat_seen_q
						&& !any_above) begin
						abort_d = 1'b1;
					end
					if (cnt_q >= LATENCY) begin
						// [RULE_02] No abort keeps going
						if (abort_d || ~|(axes_q & double_en)) begin
							state_d = TDC_IDLE;
						end else begin
							state_d = TDC_WINDOW;
						end
						cnt_d = TDC_COUNT_RST;
					end else begin
						cnt_d = cnt_inc;
					end
				end
				TDC_WINDOW: begin
					if (|(above & axes_q)) begin
						state_d = TDC_SECOND;
						cnt_d = TDC_COUNT_RST;
						sign_d = neg;
					end else if (cnt_q >= WINDOW) begin
						state_d = TDC_IDLE;
					end else begin
						cnt_d = cnt_inc;
					end
				end
				TDC_SECOND: begin
					// [RULE_19] Second tap time limit
					if (tap_ended) begin
						ev.valid = 1'b1;
						ev.dbl = 1'b1;
						ev.axes = axes_q & double_en;
						ev.sign = sign_q;
						state_d = TDC_IDLE;
					end else if (cnt_q >= TIME_LIMIT) begin
						state_d = TDC_IDLE;
					end else begin
						cnt_d = cnt_inc;
					end
				end
				default: begin
					state_d = TDC_IDLE;
				end
			endcase
		end
	end

	// Source register update
	// [RULE_05] Enabled events only
	wire ev_seen = ev.valid && (|ev.axes);
	// [RULE_11] Latched event freezes fields
	wire frozen = cfg_q.flag_latch_on && src_q.tap_event_active;
	always_comb begin
		src_d = src_q;
		// [RULE_12] Read clears all
		if (rd_src) begin
			src_d = TDC_SOURCE_RST;
		end
		// [RULE_04] Latch holds until read
		// [RULE_21] Unlatched updates per event
		if (ev_seen && (rd_src || !frozen)) begin
			// [RULE_07] Event active
			src_d.tap_event_active = 1'b1;
			// [RULE_08] Axis flags
			src_d.tap_flag = ev.axes;
			// [RULE_09] Tap type
			src_d.double_tap_type = ev.dbl;
			// [RULE_10] Axis signs
			src_d.tap_sign = ev.sign & ev.axes;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= TDC_IDLE;
			cnt_q <= TDC_COUNT_RST;
			axes_q <= 3'h0;
			sign_q <= 3'h0;
			lat_seen_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			axes_q <= axes_d;
			sign_q <= sign_d;
			lat_seen_q <= lat_seen_d;
			abort_q <= abort_d;
		end
	end

	// Configuration and threshold registers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cfg_q <= TDC_CONFIG_RST;
			// [RULE_18] Thresholds reset
			thr_x_q <= TDC_THR_RST;
			thr_y_q <= TDC_THR_RST;
			thr_z_q <= TDC_THR_RST;
		end else begin
			// [RULE_01] Config write
			if (wr_cfg) begin
				cfg_q <= tdc_config_t'(REG_WDATA);
			end
			// [RULE_13] Threshold writes
			if (wr_thx) begin
				thr_x_q <= REG_WDATA[6:0];
			end
			if (wr_thy) begin
				thr_y_q <= REG_WDATA[6:0];
			end
			if (wr_thz) begin
				thr_z_q <= REG_WDATA[6:0];
			end
		end
	end

	// Status and read data
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			src_q <= TDC_SOURCE_RST;
			rdata_q <= 8'h00;
		end else begin
			// [RULE_06] Read-only source
			src_q <= src_d;
			if (REG_RD) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign REG_RDATA = rdata_q;
	// [RULE_12] Request follows event active
	assign TAP_IRQ = src_q.tap_event_active;

endmodule

// ===== testbench/tdc_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ns
module tdc_host (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output logic [7:0] addr,
	output logic wr,
	output logic rd,
	output logic [7:0] wdata
);
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
	end
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task read_reg(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		q = rdata;
	endtask
endmodule

// ===== testbench/tdc_chk.sv
// Assertions on the tap block ports
`timescale 1ns/1ns
module tdc_chk
	import tdc_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic SAMPLE_VALID,
	input wire logic TAP_IRQ
);
	wire rs = REG_RD && REG_ADDR == TDC_ADDR_SOURCE;
	wire rt = REG_RD && REG_ADDR >= TDC_ADDR_THR_X
		&& REG_ADDR <= TDC_ADDR_THR_Z;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	irq_clear_a: assert property (
		rs && !SAMPLE_VALID |=> !TAP_IRQ) else $error("irq kept");
	src_empty_a: assert property (
		rs && !TAP_IRQ |=> REG_RDATA == 8'h00) else $error("src set");
	src_active_a: assert property (
		rs |=> REG_RDATA[7] == $past(TAP_IRQ)) else $error("bit 7");
	axis_flag_a: assert property (
		rs && TAP_IRQ |=> REG_RDATA[6:4] != 3'h0) else $error("no axis");
	sign_mask_a: assert property (
		rs |=> (REG_RDATA[2:0] & ~REG_RDATA[6:4]) == 3'h0) else $error("sign");
	thr_msb_a: assert property (
		rt |=> !REG_RDATA[7]) else $error("thr bit 7");
	irq_cause_a: assert property (
		$rose(TAP_IRQ) |-> $past(SAMPLE_VALID)) else $error("irq cause");
	irq_hold_a: assert property (
		TAP_IRQ && !rs |=> TAP_IRQ) else $error("irq lost");
	cover property (rs && TAP_IRQ);
	cover property ($rose(TAP_IRQ));
	cover property (rt);
	cover property (rs ##1 REG_RDATA[3]);
endmodule
bind tdc_core tdc_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.SAMPLE_VALID(SAMPLE_VALID), .TAP_IRQ(TAP_IRQ));

// ===== testbench/tb_top.sv
// Self-checking bench for the tap register block
`timescale 1ns/1ns
module tb_top
	import tdc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sv = 1'b0;
	logic ln = 1'b0;
	logic signed [7:0] acc [3] = '{default: 8'sh00};
	logic [7:0] addr, wdata, rdata, q, d;
	logic wr, rd, irq;
	int miscompares = 0;
	int n_compared = 0;
	int seed = 24823;
	int thr, ax, sg, lt;
	always #4 clk = ~clk;
	tdc_core u_tdc_core (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr),
		.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.SAMPLE_VALID(sv), .ACC_X(acc[0]), .ACC_Y(acc[1]), .ACC_Z(acc[2]),
		.LOW_NOISE(ln), .TIME_LIMIT(8'h03), .LATENCY(8'h02),
		.WINDOW(8'h04), .TAP_IRQ(irq));
	tdc_host u_tdc_host (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
		.rd(rd), .wdata(wdata));
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task w(input logic [7:0] a, input logic [7:0] v);
		u_tdc_host.write_reg(a, v);
	endtask
	task r(input logic [7:0] a, input logic [7:0] e);
		u_tdc_host.read_reg(a, q);
		chk(q, e);
	endtask
	task samp(input int x, input logic signed [7:0] v);
		@(posedge clk);
		for (int i = 0; i < 3; i++)
			acc[i] <= i == x ? v : 8'sh00;
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		#1;
	endtask
	task tap(input int x, input logic signed [7:0] v);
		samp(x, v);
		samp(x, 8'sh00);
	endtask
	task quiet(input int n);
		repeat (n) samp(0, 8'sh00);
	endtask
	function logic [7:0] exp_rb(input int a, input logic [7:0] v);
		if (a == TDC_ADDR_CONFIG)
			return v;
		if (a >= TDC_ADDR_THR_X && a <= TDC_ADDR_THR_Z)
			return {1'b0, v[6:0]};
		return 8'h00;
	endfunction
	function logic [7:0] exp_src(input int x, input int s, input int db);
		return 8'h80 | (8'h10 << x) | (db ? 8'h08 : 8'h00) | (8'(s) << x);
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 8'h21; a < 8'h26; a++)
			r(8'(a), 8'h00);
		for (int a = 8'h20; a < 8'h27; a++) begin
			d = 8'($random(seed));
			w(8'(a), d);
			r(8'(a), exp_rb(a, d));
		end
		for (int k = 0; k < 12; k++) begin
			ax = k % 3;
			sg = (k / 3) % 2;
			lt = k / 6;
			thr = 1 + {$random(seed)} % 100;
			w(TDC_ADDR_THR_X + 8'(ax), 8'(thr));
			w(TDC_ADDR_CONFIG, 8'(lt << 6 | 1 << 2 * ax));
			tap(ax, sg ? -8'(thr) : 8'(thr));
			chk({7'h00, irq}, 8'h00);
			tap(ax, sg ? -8'(thr + 1) : 8'(thr + 1));
			chk({7'h00, irq}, 8'h01);
			quiet(4);
			tap(ax, sg ? 8'(thr + 1) : -8'(thr + 1));
			quiet(4);
			r(TDC_ADDR_SOURCE, exp_src(ax, lt ? sg : 1 - sg, 0));
			r(TDC_ADDR_SOURCE, 8'h00);
		end
		w(TDC_ADDR_CONFIG, 8'h41);
		w(TDC_ADDR_THR_X, 8'h64);
		w(TDC_ADDR_THR_Y, 8'h01);
		tap(1, 8'h46);
		r(TDC_ADDR_SOURCE, 8'h00);
		quiet(4);
		@(posedge clk);
		ln <= 1'b1;
		tap(0, 8'h46);
		@(posedge clk);
		ln <= 1'b0;
		r(TDC_ADDR_SOURCE, 8'h90);
		quiet(4);
		w(TDC_ADDR_CONFIG, 8'h42);
		w(TDC_ADDR_THR_X, 8'h14);
		tap(0, 8'h1E);
		quiet(3);
		tap(0, 8'hE2);
		r(TDC_ADDR_SOURCE, 8'h99);
		// Tap inside latency, abort off: double still seen
		tap(0, 8'h1E);
		tap(0, 8'h1E);
		quiet(1);
		tap(0, 8'h1E);
		r(TDC_ADDR_SOURCE, 8'h98);
		// Abort on: the late tap starts over as a first tap
		w(TDC_ADDR_CONFIG, 8'hC2);
		tap(0, 8'h1E);
		tap(0, 8'h1E);
		quiet(1);
		tap(0, 8'h1E);
		r(TDC_ADDR_SOURCE, 8'h00);
		report_and_stop;
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end
endmodule
